// ==== rcem_chan_lookup.sv ====
// Combinational lookup: is a receive channel accepted under the current map.
// Assumes the owner holds the enable and control map inputs stable from its own flip-flops; chan is driven straight from i_rx_chan.
`timescale 1ns/10ps
module rcem_chan_lookup
	import rcem_pkg::*;
(
	rcem_map_if.lookup m
);
	// In select mode pick the enable map bit for the channel in hand, 0 if no block matches; otherwise every channel passes
	always_comb begin
		logic [2:0] blk;
		blk = m.chan[6:4];
		if (!m.sel_mode) begin
			m.enabled = 1'b1;
		end else if (m.part_mode) begin
			m.enabled = m.en[m.chan[6:5]][m.chan[4:0]];
		end else if (blk == {m.blk_a, 1'b0}) begin
			m.enabled = m.en[0][{1'b0, m.chan[3:0]}];
		end else if (blk == {m.blk_b, 1'b1}) begin
			m.enabled = m.en[0][{1'b1, m.chan[3:0]}];
		end else begin
			m.enabled = 1'b0;
		end
	end
endmodule : rcem_chan_lookup

// ==== rcem_chk.sv ====
// Port checker for the receive channel enable map top.
// Assumes it is bound to the top by the bench.
`timescale 1ns/10ps
`include "rcem_defines.svh"
module rcem_chk #(
	parameter int DATA_W = 32
) (
	input wire logic              i_sys_clk,
	input wire logic              i_rstn,
	input wire logic [4:0]        i_avs_address,
	input wire logic              i_avs_read,
	input wire logic              i_avs_write,
	input wire logic [31:0]       i_avs_writedata,
	input wire logic [3:0]        i_avs_byteenable,
	input wire logic              o_avs_waitrequest,
	input wire logic              i_rx_valid,
	input wire logic [DATA_W-1:0] i_rx_data,
	input wire logic [DATA_W-1:0] o_rx_data,
	input wire logic              o_rx_ready,
	input wire logic              o_rx_drop
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	logic sel_ff;
	// Shadow of the select-mode control bit
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn)
			sel_ff <= 1'b0;
		else if (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
			&& i_avs_address == `RCEM_OFS_CTRL)
			sel_ff <= i_avs_writedata[0];
	end
	// One wait cycle then the answer
	sequence s_answer;
		o_avs_waitrequest ##1 !o_avs_waitrequest;
	endsequence
	AST_RD_WAIT: assert property ($rose(i_avs_read) |-> s_answer)
		else $error("read answer timing wrong");
	AST_WR_WAIT: assert property ($rose(i_avs_write) |-> s_answer)
		else $error("write answer timing wrong");
	AST_BUS_IDLE: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
		else $error("waitrequest while idle");
	AST_ONE_ANSWER: assert property (i_rx_valid |=> o_rx_ready != o_rx_drop)
		else $error("element not answered once");
	AST_NO_ANSWER: assert property (!i_rx_valid |=> !(o_rx_ready || o_rx_drop))
		else $error("pulse without element");
	AST_ALL_OPEN: assert property (i_rx_valid && !sel_ff |=> o_rx_ready)
		else $error("element refused outside select mode");
	AST_DATA: assert property (i_rx_valid ##1 o_rx_ready |-> o_rx_data == $past(i_rx_data))
		else $error("accepted data wrong");
	AST_DROP_HOLD: assert property (o_rx_drop |-> $stable(o_rx_data))
		else $error("dropped element changed data");
endmodule : rcem_chk

// ==== rcem_defines.svh ====
// Offsets, field positions, reset values and sizes of the receive channel
// enable map. Assumes byte addressing on a 32-bit bus with word-aligned registers.
`ifndef RCEM_DEFINES_SVH
`define RCEM_DEFINES_SVH

`define RCEM_ADDR_W        5
`define RCEM_NUM_EN_REGS   4
`define RCEM_CHAN_W        7
`define RCEM_CNT_W         16

`define RCEM_OFS_EN0       5'h00
`define RCEM_OFS_EN1       5'h04
`define RCEM_OFS_EN2       5'h08
`define RCEM_OFS_EN3       5'h0c
`define RCEM_OFS_CTRL      5'h10
`define RCEM_OFS_DROP      5'h14
`define RCEM_OFS_ACCEPT    5'h18

`define RCEM_CTRL_SEL_BIT  0
`define RCEM_CTRL_PART_BIT 1
`define RCEM_CTRL_PA_LSB   2
`define RCEM_CTRL_PB_LSB   4
`define RCEM_STAT_BLK_LSB  16

`define RCEM_RST_EN        32'h0000_0000
`define RCEM_RST_CTRL      6'h00
`define RCEM_RST_CNT       16'h0000

`endif

// ==== rcem_framer_model.sv ====
// Model of the serial framer that delivers time-slotted elements.
// Assumes the bench pulses i_go for one cycle per element.
`timescale 1ns/10ps
module rcem_framer_model (
	input wire logic        i_clk,
	input wire logic        i_go,
	input wire logic [6:0]  i_chan,
	output logic            o_valid,
	output logic [6:0]      o_chan,
	output logic [31:0]     o_data
);
	initial begin
		o_valid = 1'b0;
		o_chan = 7'h00;
		o_data = 32'h0000_0000;
	end
	// One-cycle element; lines show the inverse of the last value between elements
	always @(posedge i_clk) begin
		o_valid <= i_go;
		o_chan <= i_go ? i_chan : ~o_chan;
		o_data <= i_go ? {16'ha5c3, 9'h000, i_chan} : ~o_data;
	end
endmodule : rcem_framer_model

// ==== rcem_map_if.sv ====
// Carrier between the register owner and the channel lookup.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/10ps
interface rcem_map_if;
	import rcem_pkg::*;
	rcem_word_t    en [4];
	logic          sel_mode;
	logic          part_mode;
	rcem_blk_sel_t blk_a;
	rcem_blk_sel_t blk_b;
	logic [6:0]    chan;
	logic          enabled;

	modport owner  (output en, sel_mode, part_mode, blk_a, blk_b, chan, input enabled);
	modport lookup (input en, sel_mode, part_mode, blk_a, blk_b, chan, output enabled);
endinterface : rcem_map_if

// ==== rcem_pkg.sv ====
// Types shared by the receive channel enable map modules.
// Assumes the constants header is compiled alongside.
package rcem_pkg;
	typedef logic [31:0] rcem_word_t;
	typedef logic [1:0]  rcem_blk_sel_t;
	typedef enum logic [0:0] {
		RCEM_BUS_IDLE,
		RCEM_BUS_ANSWER
	} rcem_bus_state_t;
endpackage : rcem_pkg

// ==== rcem_top.sv ====
// Receive channel enable map: four enable registers, a control register,
// status counters and the accept/discard gate for received elements.
// Assumes an Avalon-MM master with waitrequest and elements synchronous to the clock.
`timescale 1ns/10ps
`include "rcem_defines.svh"

module rcem_top
	import rcem_pkg::*;
#(
	parameter int DATA_W = 32
) (
	input  wire logic                     i_sys_clk,
	input  wire logic                     i_rstn,
	// Avalon-MM slave
	input  wire logic [`RCEM_ADDR_W-1:0]  i_avs_address,
	input  wire logic                     i_avs_read,
	input  wire logic                     i_avs_write,
	input  wire logic [31:0]              i_avs_writedata,
	input  wire logic [3:0]               i_avs_byteenable,
	output logic      [31:0]              o_avs_readdata,
	output logic                          o_avs_waitrequest,
	// Received elements from the serial framer
	input  wire logic                     i_rx_valid,
	input  wire logic [`RCEM_CHAN_W-1:0]  i_rx_chan,
	input  wire logic [DATA_W-1:0]        i_rx_data,
	output logic      [DATA_W-1:0]        o_rx_data,
	output logic                          o_rx_ready,
	output logic                          o_rx_drop
);

	// Element width must fit one bus word
	initial begin
		if (DATA_W < 1 || DATA_W > 32) begin
			$error("rcem_top: DATA_W must lie in 1..32");
		end
	end

	// Word index decode, shared by read and write paths
	function automatic logic [3:0] reg_sel(input logic [`RCEM_ADDR_W-1:0] addr);
		logic [3:0] sel;
		sel = 4'hf;
		case (addr)
			`RCEM_OFS_EN0:    sel = 4'h0;
			`RCEM_OFS_EN1:    sel = 4'h1;
			`RCEM_OFS_EN2:    sel = 4'h2;
			`RCEM_OFS_EN3:    sel = 4'h3;
			`RCEM_OFS_CTRL:   sel = 4'h4;
			`RCEM_OFS_DROP:   sel = 4'h5;
			`RCEM_OFS_ACCEPT: sel = 4'h6;
			default:          sel = 4'hf;
		endcase
		return sel;
	endfunction : reg_sel

	// Byte-lane merge of write data into an old word
	function automatic rcem_word_t be_merge(input rcem_word_t old_w,
	                                        input rcem_word_t new_w,
	                                        input logic [3:0] be);
		rcem_word_t res;
		res = old_w;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[8*i +: 8] = new_w[8*i +: 8];
			end
		end
		return res;
	endfunction : be_merge

	rcem_bus_state_t         bus_state_ff;
	rcem_bus_state_t         nxt_bus_state;
	logic                    req;
	logic                    wr_take;
	logic [3:0]              sel;
	rcem_word_t              en_ff [`RCEM_NUM_EN_REGS];
	logic [5:0]              ctrl_ff;
	logic [`RCEM_CNT_W-1:0]  drop_cnt_ff;
	logic [`RCEM_CNT_W-1:0]  accept_cnt_ff;
	logic [2:0]              last_blk_ff;
	rcem_word_t              rd_mux;
	rcem_word_t              readdata_ff;
	logic [DATA_W-1:0]       rx_data_ff;
	logic                    rx_ready_ff;
	logic                    rx_drop_ff;

	rcem_map_if u_map ();

	// Request decode and the write moment
	assign req     = i_avs_read | i_avs_write;
	assign sel     = reg_sel(i_avs_address);
	assign wr_take = i_avs_write && (bus_state_ff == RCEM_BUS_ANSWER);

	// Waitrequest holds off the first cycle of every request
	assign o_avs_waitrequest = req && (bus_state_ff == RCEM_BUS_IDLE);

	// Bus answer sequencing
	always_comb begin
		nxt_bus_state = bus_state_ff;
		case (bus_state_ff)
			RCEM_BUS_IDLE: begin
				if (req) begin
					nxt_bus_state = RCEM_BUS_ANSWER;
				end
			end
			RCEM_BUS_ANSWER: begin
				nxt_bus_state = RCEM_BUS_IDLE;
			end
			default: begin
				nxt_bus_state = RCEM_BUS_IDLE;
			end
		endcase
	end

	// Bus state register
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			bus_state_ff <= RCEM_BUS_IDLE;
		end else begin
			bus_state_ff <= nxt_bus_state;
		end
	end

	// Enable registers, one per 32-channel group
	generate
		for (genvar r = 0; r < `RCEM_NUM_EN_REGS; r++) begin : g_en
			always_ff @(posedge i_sys_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					en_ff[r] <= `RCEM_RST_EN;
				end else if (wr_take && sel == 4'(r)) begin
					en_ff[r] <= be_merge(en_ff[r], i_avs_writedata, i_avs_byteenable);
				end
			end
			assign u_map.en[r] = en_ff[r];
		end
	endgenerate

	// Control register: select mode, partition mode, block fields
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl_ff <= `RCEM_RST_CTRL;
		end else if (wr_take && sel == 4'h4 && i_avs_byteenable[0]) begin
			ctrl_ff <= i_avs_writedata[5:0];
		end
	end

	// Map inputs to the lookup
	assign u_map.sel_mode  = ctrl_ff[`RCEM_CTRL_SEL_BIT];
	assign u_map.part_mode = ctrl_ff[`RCEM_CTRL_PART_BIT];
	assign u_map.blk_a     = ctrl_ff[`RCEM_CTRL_PA_LSB +: 2];
	assign u_map.blk_b     = ctrl_ff[`RCEM_CTRL_PB_LSB +: 2];
	assign u_map.chan      = i_rx_chan;

	// Channel lookup against the current map
	rcem_chan_lookup u_lookup (
		.m (u_map.lookup)
	);

	// Read multiplexer; unmapped words read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (sel)
			4'h0, 4'h1, 4'h2, 4'h3: rd_mux = en_ff[sel[1:0]];
			4'h4:    rd_mux = {26'h000_0000, ctrl_ff};
			4'h5:    rd_mux = {13'h0000, last_blk_ff, drop_cnt_ff};
			4'h6:    rd_mux = {16'h0000, accept_cnt_ff};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data captured in the waiting cycle, stands at the taking edge
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			readdata_ff <= 32'h0000_0000;
		end else if (i_avs_read && bus_state_ff == RCEM_BUS_IDLE) begin
			readdata_ff <= rd_mux;
		end
	end

	assign o_avs_readdata = readdata_ff;

	// Accept or discard each arriving element
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_ready_ff <= 1'b0;
			rx_drop_ff  <= 1'b0;
		end else begin
			rx_ready_ff <= i_rx_valid && u_map.enabled;
			rx_drop_ff  <= i_rx_valid && !u_map.enabled;
		end
	end

	// Element data loaded only for enabled channels
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_data_ff <= '0;
		end else if (i_rx_valid && u_map.enabled) begin
			rx_data_ff <= i_rx_data;
		end
	end

	// Block of the most recent element
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			last_blk_ff <= 3'h0;
		end else if (i_rx_valid) begin
			last_blk_ff <= i_rx_chan[6:4];
		end
	end

	// Discard counter, wraps
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			drop_cnt_ff <= `RCEM_RST_CNT;
		end else if (i_rx_valid && !u_map.enabled) begin
			drop_cnt_ff <= drop_cnt_ff + 16'h0001;
		end
	end

	// Accept counter, wraps
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			accept_cnt_ff <= `RCEM_RST_CNT;
		end else if (i_rx_valid && u_map.enabled) begin
			accept_cnt_ff <= accept_cnt_ff + 16'h0001;
		end
	end

	// Element outputs
	assign o_rx_data  = rx_data_ff;
	assign o_rx_ready = rx_ready_ff;
	assign o_rx_drop  = rx_drop_ff;

endmodule : rcem_top

// ==== receive_channel_enable_map_tb_top.sv ====
// Self-checking bench for the receive channel enable map.
// Assumes the checker and framer model are compiled before it.
`timescale 1ns/10ps
module receive_channel_enable_map_tb_top;
	logic sys_clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, go = 1'b0;
	logic [4:0] adr = 5'h00;
	logic [31:0] wd = 32'h0000_0000, rdat, rxd, dat, last = 32'h0000_0000;
	logic [6:0] chn = 7'h00, mch;
	logic [3:0] be = 4'hf;
	logic [2:0] lblk = 3'h0;
	int acc_n = 0, drp_n = 0;
	logic wreq, rdy, drop, vld;
	int error_cnt = 0, check_count = 0;
	rcem_top rcem_top_inst (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
		.i_rx_valid(vld), .i_rx_chan(mch), .i_rx_data(dat), .o_rx_data(rxd),
		.o_rx_ready(rdy), .o_rx_drop(drop));
	rcem_framer_model rcem_framer_model_inst (.i_clk(sys_clk), .i_go(go), .i_chan(chn),
		.o_valid(vld), .o_chan(mch), .o_data(dat));
	// Clock at 25 MHz
	always #20 sys_clk = ~sys_clk;
	task results;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results
	task chk(input logic ok, input string m);
		check_count++;
		if (!ok) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask : chk
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge sys_clk);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 20) begin
			chk(1'b0, "bus timeout");
			results;
		end
	endtask : bus
	task wrt(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wrt
	task rdc(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q === e, "read value");
	endtask : rdc
	task send(input int c, input logic ok);
		@(posedge sys_clk);
		go <= 1'b1;
		chn <= 7'(c);
		@(posedge sys_clk);
		go <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk(rdy === ok && drop === !ok, "accept or drop");
		if (ok) begin
			last = {16'ha5c3, 9'h000, 7'(c)};
			acc_n++;
		end else
			drp_n++;
		lblk = 3'(c >> 4);
		chk(rxd === last, "element data");
	endtask : send
	// Control readback, lane-0 gating and status counters
	task t_stat;
		rdc(5'h10, 32'h0000_0031);
		be <= 4'he;
		wrt(5'h10, 32'h0000_0000);
		be <= 4'hf;
		rdc(5'h10, 32'h0000_0031);
		rdc(5'h14, {13'h0000, lblk, 16'(drp_n)});
		rdc(5'h18, {16'h0000, 16'(acc_n)});
	endtask : t_stat
	// Reset in mid-run clears written enable bits
	task t_rst;
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		rdc(5'h00, 32'h0000_0000);
		rdc(5'h10, 32'h0000_0000);
	endtask : t_rst
	task t_regs;
		for (int r = 0; r < 4; r++) rdc(5'(r * 4), 32'h0000_0000);
		for (int r = 0; r < 4; r++) wrt(5'(r * 4), 32'h1234_5670 + r);
		for (int r = 0; r < 4; r++) rdc(5'(r * 4), 32'h1234_5670 + r);
		rdc(5'h1c, 32'h0000_0000);
	endtask : t_regs
	task t_all;
		for (int r = 0; r < 4; r++) wrt(5'(r * 4), 32'h0000_0000);
		wrt(5'h10, 32'h0000_0002);
		send(0, 1'b1);
		send(127, 1'b1);
	endtask : t_all
	task t_wide;
		wrt(5'h10, 32'h0000_0003);
		for (int r = 0; r < 4; r++) wrt(5'(r * 4), 32'h8000_0001);
		for (int r = 0; r < 4; r++) begin
			send(32 * r, 1'b1);
			send(32 * r + 31, 1'b1);
			send(32 * r + 1, 1'b0);
		end
	endtask : t_wide
	task t_split;
		wrt(5'h00, 32'h0001_8000);
		for (int c = 0; c < 4; c++) begin
			wrt(5'h10, {26'h000_0000, 2'(c), 2'(3 - c), 2'b01});
			send(32 * (3 - c) + 15, 1'b1);
			send(32 * (3 - c) + 14, 1'b0);
			send(32 * c + 16, 1'b1);
			send(32 * c + 17, 1'b0);
			send(32 * ((c + 1) % 4) + 16, 1'b0);
		end
	endtask : t_split
	// Main sequence
	initial begin
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		t_regs;
		t_all;
		t_wide;
		t_split;
		t_stat;
		t_rst;
		results;
	end
endmodule : receive_channel_enable_map_tb_top
bind rcem_top rcem_chk #(.DATA_W(DATA_W)) rcem_chk_inst (.i_sys_clk(i_sys_clk),
	.i_rstn(i_rstn), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
	.i_avs_byteenable(i_avs_byteenable), .o_avs_waitrequest(o_avs_waitrequest),
	.i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .o_rx_data(o_rx_data),
	.o_rx_ready(o_rx_ready), .o_rx_drop(o_rx_drop));
